// [src/pcseq_pkg.sv]
package pcseq_pkg;
  localparam int PCSEQ_PC_W = 16;
  localparam int PCSEQ_BYTE_W = 8;
  localparam int PCSEQ_JUMP_W = 13;
  localparam int PCSEQ_PAGE_LO = 13;
  localparam int PCSEQ_LATCH_PAGE_LO = 5;
  localparam int PCSEQ_OPC_HI_LO = 8;
  localparam logic [15:0] PCSEQ_PC_RST = 16'h0000;
  localparam logic [7:0] PCSEQ_LATCH_RST = 8'h00;
  localparam logic [15:0] PCSEQ_INT_VECTOR_RST = 16'h0020;

  // Operation codes presented by the instruction decoder
  typedef enum logic [3:0] {
    PCSEQ_OP_NONE = 4'h0,
    PCSEQ_OP_FETCH = 4'h1,
    PCSEQ_OP_SKIP = 4'h2,
    PCSEQ_OP_JUMP = 4'h3,
    PCSEQ_OP_CALL = 4'h4,
    PCSEQ_OP_LONG_CALL = 4'h5,
    PCSEQ_OP_RETURN = 4'h6,
    PCSEQ_OP_RETLIT = 4'h7,
    PCSEQ_OP_RETINT = 4'h8,
    PCSEQ_OP_INTVEC = 4'h9,
    PCSEQ_OP_RD_LOW = 4'hA,
    PCSEQ_OP_WR_LOW = 4'hB,
    PCSEQ_OP_RMW_LOW = 4'hC,
    PCSEQ_OP_RD_LATCH = 4'hD,
    PCSEQ_OP_WR_LATCH = 4'hE
  } pcseq_op_t;
endpackage : pcseq_pkg

// [src/pcseq_next_pc.sv]
`timescale 1ns/1ps
`default_nettype none
module pcseq_next_pc
  import pcseq_pkg::*;
(
  input wire pcseq_op_t op_i,
  input wire logic [15:0] pc_i,
  input wire logic [7:0] latch_i,
  input wire logic [15:0] opcode_i,
  input wire logic [7:0] data_i,
  input wire logic [15:0] stack_i,
  input wire logic [15:0] vector_i,
  output logic [15:0] pc_o,
  output logic [7:0] latch_o
);
  always_comb begin
    pc_o = pc_i;
    latch_o = latch_i;
    unique case (op_i)
      PCSEQ_OP_FETCH, PCSEQ_OP_SKIP: begin
        pc_o = pc_i + 16'h0001;
      end
      PCSEQ_OP_JUMP, PCSEQ_OP_CALL: begin
        pc_o = {pc_i[15:13], opcode_i[12:0]};
        latch_o = {pc_i[15:13], opcode_i[12:8]};
      end
      PCSEQ_OP_LONG_CALL: begin
        pc_o = {latch_i, opcode_i[7:0]};
      end
      PCSEQ_OP_RETURN, PCSEQ_OP_RETLIT, PCSEQ_OP_RETINT: begin
        pc_o = stack_i;
      end
      PCSEQ_OP_INTVEC: begin
        pc_o = vector_i;
      end
      PCSEQ_OP_RD_LOW: begin
        latch_o = pc_i[15:8];
      end
      PCSEQ_OP_WR_LOW, PCSEQ_OP_RMW_LOW: begin
        pc_o = {latch_i, data_i};
      end
      PCSEQ_OP_WR_LATCH: begin
        latch_o = data_i;
      end
      default: begin
        pc_o = pc_i;
      end
    endcase
  end
endmodule : pcseq_next_pc
`default_nettype wire

// [src/pcseq_top.sv]
// Functional notes
// - A 16-bit program counter whose low byte is read and written like data.
// - The high byte is unaddressed and reached only through an 8-bit holding latch.
// - The counter increments on each fetch unless a transfer or low-byte write overrides it.
// - A skipped instruction costs one forced no-operation cycle at its address.
// - A long call loads low byte from opcode and high byte from the latch, latch kept.
// - Reading the low byte drives it on the data bus and copies the high byte to the latch.
// - Writing the low byte takes bus data and moves the latch into the high byte.
// - A read-modify-write on the low byte writes the result and the high byte from latch at one edge.
// - Call or jump loads bits 12..0 from opcode and refreshes the latch page and bits.
// - Long call, returns, vectoring and read-modify-write leave the latch unchanged.
`timescale 1ns/1ps
`default_nettype none
module pcseq_top
  import pcseq_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire pcseq_op_t op_i,
  input wire logic [15:0] opcode_i,
  input wire logic [7:0] data_i,
  input wire logic [15:0] stack_i,
  input wire logic [15:0] vector_i,
  output logic [15:0] pc_o,
  output logic [7:0] latch_o,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  output logic nop_forced_o
);
  typedef struct packed {
    logic [15:0] pc;
    logic [7:0] latch;
    logic [7:0] rd_data;
    logic rd_valid;
    logic nop_forced;
  } pcseq_state_t;

  pcseq_state_t state_reg;
  pcseq_state_t state_next;
  logic [15:0] pc_calc;
  logic [7:0] latch_calc;

  // Low-byte reads share one bus path
  function automatic logic pcseq_is_low_read(input pcseq_op_t op);
    pcseq_is_low_read = (op == PCSEQ_OP_RD_LOW) || (op == PCSEQ_OP_RMW_LOW);
  endfunction : pcseq_is_low_read

  pcseq_next_pc u_next (
    .op_i(op_i),
    .pc_i(state_reg.pc),
    .latch_i(state_reg.latch),
    .opcode_i(opcode_i),
    .data_i(data_i),
    .stack_i(stack_i),
    .vector_i(vector_i),
    .pc_o(pc_calc),
    .latch_o(latch_calc)
  );

  always_comb begin
    state_next = state_reg;
    state_next.pc = pc_calc;
    state_next.latch = latch_calc;
    state_next.rd_valid = 1'b0;
    state_next.nop_forced = (op_i == PCSEQ_OP_SKIP);
    if (pcseq_is_low_read(op_i)) begin
      state_next.rd_data = state_reg.pc[7:0];
      state_next.rd_valid = 1'b1;
    end else if (op_i == PCSEQ_OP_RD_LATCH) begin
      state_next.rd_data = state_reg.latch;
      state_next.rd_valid = 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state_reg <= '{pc: PCSEQ_PC_RST, latch: PCSEQ_LATCH_RST, rd_data: 8'h00,
                     rd_valid: 1'b0, nop_forced: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign pc_o = state_reg.pc;
  assign latch_o = state_reg.latch;
  assign rd_data_o = state_reg.rd_data;
  assign rd_valid_o = state_reg.rd_valid;
  assign nop_forced_o = state_reg.nop_forced;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  chk_fetch_incr: assert property (
    op_i == PCSEQ_OP_FETCH |=> pc_o == $past(pc_o) + 16'h0001)
    else $error("fetch did not increment counter");

  chk_fetch_latch: assert property (
    op_i inside {PCSEQ_OP_FETCH, PCSEQ_OP_SKIP} |=> latch_o == $past(latch_o))
    else $error("fetch changed latch");

  chk_skip_incr: assert property (
    op_i == PCSEQ_OP_SKIP |=> pc_o == $past(pc_o) + 16'h0001)
    else $error("skip did not advance counter");

  chk_long_call_load: assert property (
    op_i == PCSEQ_OP_LONG_CALL |=> pc_o == {$past(latch_o), $past(opcode_i[7:0])}
      && latch_o == $past(latch_o))
    else $error("long call load wrong");

  chk_rd_low_copy: assert property (
    op_i == PCSEQ_OP_RD_LOW |=> rd_valid_o && rd_data_o == $past(pc_o[7:0])
      && latch_o == $past(pc_o[15:8]))
    else $error("low read wrong");

  chk_rd_pulse: assert property (
    !(pcseq_is_low_read(op_i) || op_i == PCSEQ_OP_RD_LATCH) |=> !rd_valid_o)
    else $error("read valid without read");

  chk_rd_hold: assert property (
    !(pcseq_is_low_read(op_i) || op_i == PCSEQ_OP_RD_LATCH) |=>
      rd_data_o == $past(rd_data_o))
    else $error("read data changed without read");

  chk_wr_low_move: assert property (
    op_i == PCSEQ_OP_WR_LOW |=> pc_o == {$past(latch_o), $past(data_i)})
    else $error("low write wrong");

  chk_wr_low_latch: assert property (
    op_i == PCSEQ_OP_WR_LOW |=> latch_o == $past(latch_o))
    else $error("low write changed latch");

  chk_rmw_read: assert property (
    op_i == PCSEQ_OP_RMW_LOW |=> rd_valid_o && rd_data_o == $past(pc_o[7:0]))
    else $error("rmw read wrong");

  chk_rmw_write: assert property (
    op_i == PCSEQ_OP_RMW_LOW |=> pc_o[7:0] == $past(data_i))
    else $error("rmw result not written");

  chk_rmw_keep: assert property (
    op_i == PCSEQ_OP_RMW_LOW |=> pc_o[15:8] == $past(latch_o) && latch_o == $past(latch_o))
    else $error("rmw wrong");

  chk_jump_page: assert property (
    op_i inside {PCSEQ_OP_JUMP, PCSEQ_OP_CALL} |=>
      pc_o == {$past(pc_o[15:13]), $past(opcode_i[12:0])}
      && latch_o == {$past(pc_o[15:13]), $past(opcode_i[12:8])})
    else $error("jump load wrong");

  chk_latch_kept: assert property (
    op_i inside {PCSEQ_OP_RETLIT, PCSEQ_OP_RETINT, PCSEQ_OP_INTVEC} |=>
      latch_o == $past(latch_o))
    else $error("latch changed");

  chk_vector_load: assert property (
    op_i == PCSEQ_OP_INTVEC |=> pc_o == $past(vector_i))
    else $error("vector load wrong");

  chk_return_load: assert property (
    op_i == PCSEQ_OP_RETURN |=> pc_o == $past(stack_i))
    else $error("return load wrong");

  chk_return_latch: assert property (
    op_i == PCSEQ_OP_RETURN |=> latch_o == $past(latch_o))
    else $error("return changed latch");

  chk_ret_other_load: assert property (
    op_i inside {PCSEQ_OP_RETLIT, PCSEQ_OP_RETINT} |=> pc_o == $past(stack_i))
    else $error("return variant load wrong");

  chk_latch_write: assert property (
    op_i == PCSEQ_OP_WR_LATCH |=> latch_o == $past(data_i) && pc_o == $past(pc_o))
    else $error("latch write wrong");

  chk_latch_read: assert property (
    op_i == PCSEQ_OP_RD_LATCH |=> rd_valid_o && rd_data_o == $past(latch_o)
      && latch_o == $past(latch_o))
    else $error("latch read wrong");

  chk_idle_hold: assert property (
    op_i == PCSEQ_OP_NONE |=> pc_o == $past(pc_o) && latch_o == $past(latch_o))
    else $error("idle changed state");

  chk_skip_nop: assert property (
    op_i == PCSEQ_OP_SKIP |=> nop_forced_o ##1 !nop_forced_o || $past(op_i) == PCSEQ_OP_SKIP)
    else $error("skip nop wrong");

  chk_nop_only_skip: assert property (
    op_i != PCSEQ_OP_SKIP |=> !nop_forced_o)
    else $error("forced nop without skip");

  // Main scenarios
  cov_jump: cover property (op_i == PCSEQ_OP_JUMP);
  cov_computed: cover property (op_i == PCSEQ_OP_WR_LATCH ##1 op_i == PCSEQ_OP_WR_LOW);
  cov_rmw: cover property (op_i == PCSEQ_OP_RMW_LOW);
  cov_long_call: cover property (op_i == PCSEQ_OP_LONG_CALL);
  cov_rd_latch: cover property (op_i == PCSEQ_OP_RD_LATCH ##1 rd_valid_o);
endmodule : pcseq_top
`default_nettype wire

// [dv/pcseq_stack_model.sv]
`timescale 1ns/1ps
`default_nettype none
module pcseq_stack_model
  import pcseq_pkg::*;
(
  input wire logic mclk_i,
  input wire pcseq_op_t op_i,
  input wire logic [15:0] pc_i,
  output logic [15:0] stack_o
);
  initial stack_o = 16'h0000;
  // Call address only, one level deep
  always @(posedge mclk_i) if (op_i == PCSEQ_OP_CALL) stack_o <= pc_i;
endmodule : pcseq_stack_model
`default_nettype wire

// [dv/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top import pcseq_pkg::*;;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  pcseq_op_t op_i = PCSEQ_OP_NONE;
  logic [15:0] opcode_i = 16'h0000;
  logic [7:0] data_i = 8'h00;
  logic [15:0] stack_i;
  logic [15:0] vector_i = PCSEQ_INT_VECTOR_RST;
  logic [15:0] pc_o;
  logic [7:0] latch_o;
  logic [7:0] rd_data_o;
  logic rd_valid_o;
  logic nop_forced_o;
  int n_fail = 0;
  int samples_checked = 0;
  initial forever #25 mclk_i = ~mclk_i;
  pcseq_top dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .op_i(op_i),
    .opcode_i(opcode_i), .data_i(data_i), .stack_i(stack_i),
    .vector_i(vector_i), .pc_o(pc_o), .latch_o(latch_o),
    .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
    .nop_forced_o(nop_forced_o));
  pcseq_stack_model ret_stack (.mclk_i(mclk_i), .op_i(op_i), .pc_i(pc_o),
    .stack_o(stack_i));
  task automatic chk(input string what, input logic [15:0] exp,
    input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Held until the next call, no double drive
  task automatic run(input pcseq_op_t op, input logic [15:0] opc,
    input logic [7:0] d);
    op_i = op;
    opcode_i = opc;
    data_i = d;
    @(posedge mclk_i);
    #1;
  endtask : run
  task automatic see(input logic [15:0] p, input logic [7:0] l);
    chk("pc", p, pc_o);
    chk("latch", {8'h00, l}, {8'h00, latch_o});
  endtask : see
  task automatic t_fetch();
    see(16'h0000, 8'h00);
    run(PCSEQ_OP_FETCH, 16'h0000, 8'h00);
    see(16'h0001, 8'h00);
    run(PCSEQ_OP_SKIP, 16'h0000, 8'h00);
    chk("nop", 16'h0001, {15'h0000, nop_forced_o});
    run(PCSEQ_OP_NONE, 16'h0000, 8'h00);
    chk("nop", 16'h0000, {15'h0000, nop_forced_o});
    see(16'h0002, 8'h00);
  endtask : t_fetch
  task automatic t_jump();
    run(PCSEQ_OP_WR_LATCH, 16'h0000, 8'hE0);
    run(PCSEQ_OP_WR_LOW, 16'h0000, 8'h10);
    see(16'hE010, 8'hE0);
    run(PCSEQ_OP_JUMP, 16'h0123, 8'h00);
    see(16'hE123, 8'hE1);
    run(PCSEQ_OP_CALL, 16'h0456, 8'h00);
    see(16'hE456, 8'hE4);
  endtask : t_jump
  task automatic t_read();
    run(PCSEQ_OP_WR_LATCH, 16'h0000, 8'h55);
    run(PCSEQ_OP_RD_LOW, 16'h0000, 8'h00);
    chk("rd_valid", 16'h0001, {15'h0000, rd_valid_o});
    chk("rd_data", 16'h0056, {8'h00, rd_data_o});
    see(16'hE456, 8'hE4);
    run(PCSEQ_OP_RD_LATCH, 16'h0000, 8'h00);
    chk("rd_valid", 16'h0001, {15'h0000, rd_valid_o});
    chk("rd_data", 16'h00E4, {8'h00, rd_data_o});
    run(PCSEQ_OP_NONE, 16'h0000, 8'h00);
    chk("rd_valid", 16'h0000, {15'h0000, rd_valid_o});
    chk("rd_data", 16'h00E4, {8'h00, rd_data_o});
    see(16'hE456, 8'hE4);
  endtask : t_read
  task automatic t_rmw_ret();
    run(PCSEQ_OP_WR_LATCH, 16'h0000, 8'h03);
    run(PCSEQ_OP_WR_LOW, 16'h0000, 8'hF0);
    run(PCSEQ_OP_RMW_LOW, 16'h0000, 8'h20);
    see(16'h0320, 8'h03);
    chk("rd_data", 16'h00F0, {8'h00, rd_data_o});
    run(PCSEQ_OP_WR_LATCH, 16'h0000, 8'h12);
    run(PCSEQ_OP_LONG_CALL, 16'h0034, 8'h00);
    see(16'h1234, 8'h12);
    run(PCSEQ_OP_RETURN, 16'h0000, 8'h00);
    chk("pc", 16'hE123, pc_o);
    run(PCSEQ_OP_INTVEC, 16'h0000, 8'h00);
    see(PCSEQ_INT_VECTOR_RST, 8'h12);
    run(PCSEQ_OP_RETLIT, 16'h0000, 8'h00);
    see(16'hE123, 8'h12);
    run(PCSEQ_OP_RETINT, 16'h0000, 8'h00);
    see(16'hE123, 8'h12);
    vector_i = 16'h0A5A;
    run(PCSEQ_OP_INTVEC, 16'h0000, 8'h00);
    see(16'h0A5A, 8'h12);
  endtask : t_rmw_ret
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  initial begin
    repeat (2) @(posedge mclk_i);
    #1;
    rst_n_i = 1'b1;
    t_fetch();
    t_jump();
    t_read();
    t_rmw_ret();
    final_report();
  end
  // About 24 cycles expected, generous margin
  initial begin
    #20000;
    n_fail++;
    final_report();
  end
endmodule : tb_top
`default_nettype wire
